// [rtl/gpabc_pkg.sv]
// Purpose: Constants for the three-port general-purpose pin block (ports A, B, C).
// Assumes: Byte-wide special-function register bus with 8-bit addresses.
// Notes: Offsets are byte addresses on the special-function bus.
package gpabc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PA_W = 4;
    localparam int PB_W = 1;
    localparam int PC_W = 6;

    localparam logic [7:0] ADDR_PA_OD = 8'ha0;
    localparam logic [7:0] ADDR_PB_OD = 8'ha1;
    localparam logic [7:0] ADDR_PC_OD = 8'ha2;
    localparam logic [7:0] ADDR_PA_PU = 8'ha5;
    localparam logic [7:0] ADDR_PB_PU = 8'ha6;
    localparam logic [7:0] ADDR_PC_PU = 8'ha7;
    localparam logic [7:0] ADDR_PA_FSEL = 8'haa;
    localparam logic [7:0] ADDR_PB_FSEL = 8'hab;
    localparam logic [7:0] ADDR_PA_DATA = 8'hc0;
    localparam logic [7:0] ADDR_PA_DIR = 8'hc1;
    localparam logic [7:0] ADDR_PB_DATA = 8'hc2;
    localparam logic [7:0] ADDR_PB_DIR = 8'hc3;
    localparam logic [7:0] ADDR_PC_DATA = 8'hc4;
    localparam logic [7:0] ADDR_PC_DIR = 8'hc5;

    // Port A pins sit at byte positions 7, 6, 4, 1
    localparam int PA_BIT0 = 1;
    localparam int PA_BIT1 = 4;
    localparam int PA_BIT2 = 6;
    localparam int PA_BIT3 = 7;
    // Function select bit positions: port A, except FS_PWM which is the port B select bit
    localparam int FS_EXT_IRQ_B = 7;
    localparam int FS_EXT_IRQ_A = 6;
    localparam int FS_BUZZER = 4;
    localparam int FS_UART_RX = 3;
    localparam int FS_UART_TX = 2;
    localparam int FS_TIMER_EVT = 1;
    localparam int FS_PWM = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] PA_DATA_MASK = 8'hd2;
    localparam logic [7:0] PA_FSEL_MASK = 8'hde;
    localparam logic [7:0] PB_MASK = 8'h01;
    localparam logic [7:0] PC_MASK = 8'h3f;
endpackage : gpabc_pkg

// [rtl/gpabc_pin.sv]
// Purpose: One bidirectional pad control cell with input synchroniser.
// Assumes: Pad resolves wire level from output enable and pull-up request.
// Notes: Open drain drives only low; a high is left to the pull-up or outside.
`timescale 1ns/1ns
module gpabc_pin (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic dir_out,
    input wire logic open_drain,
    input wire logic pullup_sel,
    input wire logic out_val,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pu,
    output logic pin_level
);
    logic sync1_q;
    logic sync2_q;
    logic oe_d;
    logic pu_d;

    // Open drain enables the driver only for a low level
    assign oe_d = dir_out & ~(open_drain & out_val);
    // Pull-up while the pin floats as input, or an open drain output released
    assign pu_d = pullup_sel & ~oe_d;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pad_pu <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            pad_out <= out_val & ~open_drain;
            pad_oe <= oe_d;
            pad_pu <= pu_d;
        end
    end

    assign pin_level = sync2_q;
endmodule : gpabc_pin

// [rtl/gpabc_ports.sv]
// Purpose: Ports A (4 pins), B (1 pin), C (6 pins) with direction, pull-up,
//          open drain and alternate-function routing.
// Assumes: CPU special-function bus: address, write strobe, read strobe with a
//          read-pin qualifier; read data is registered one cycle after the strobe.
// Notes: Control registers are write-only and read back as zero.
`timescale 1ns/1ns

// Behaviour
// - Port A: four pins at bits 7,6,4,1
// - Direction bit 1 output, 0 input
// - Pull-up bit 1 connects, 0 disconnects; code connects it only while the pin driver is off
// - Port A registers reset to zero
// - Port A function select resets zero
// - Function select 1 routes pin to peripheral
// - Port A select bit layout fixed
// - Pins 7,6,4,1 carry irq, buzzer, timer
// - Control registers write-only, byte writes only
// - Port B single pin, registers reset zero
// - Port B select picks PWM/timer output
// - Port C six pins with registers
// - Open drain bit 1 open drain
// - Input with pull-up floats high
// - Data read returns latch or pin
module gpabc_ports #(
    parameter int PA_W = gpabc_pkg::PA_W,
    parameter int PB_W = gpabc_pkg::PB_W,
    parameter int PC_W = gpabc_pkg::PC_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [gpabc_pkg::ADDR_W-1:0] sfr_addr,
    input wire logic [gpabc_pkg::DATA_W-1:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rd_pin,
    output logic [gpabc_pkg::DATA_W-1:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic [PA_W-1:0] pa_pad_in,
    output logic [PA_W-1:0] pa_pad_out,
    output logic [PA_W-1:0] pa_pad_oe,
    output logic [PA_W-1:0] pa_pad_pu,
    input wire logic [PB_W-1:0] pb_pad_in,
    output logic [PB_W-1:0] pb_pad_out,
    output logic [PB_W-1:0] pb_pad_oe,
    output logic [PB_W-1:0] pb_pad_pu,
    input wire logic [PC_W-1:0] pc_pad_in,
    output logic [PC_W-1:0] pc_pad_out,
    output logic [PC_W-1:0] pc_pad_oe,
    output logic [PC_W-1:0] pc_pad_pu,
    input wire logic buzzer_out,
    input wire logic uart_tx_out,
    input wire logic timer2_wave_out,
    output logic ext_irq_a_in,
    output logic ext_irq_b_in,
    output logic timer_event_in,
    output logic uart_tx_en,
    output logic uart_rx_en
);
    logic [7:0] pa_data_q, pa_dir_q, pa_pu_q, pa_od_q, pa_fsel_q;
    logic [7:0] pb_data_q, pb_dir_q, pb_pu_q, pb_od_q, pb_fsel_q;
    logic [7:0] pc_data_q, pc_dir_q, pc_pu_q, pc_od_q;
    logic [7:0] rdata_d;
    logic [PA_W-1:0] pa_lvl, pa_dir, pa_od, pa_pu, pa_val, pa_fs, pa_alt_out;
    logic [PA_W-1:0] pa_alt_is_out, pa_alt_is_in;
    logic [PB_W-1:0] pb_lvl, pb_dir, pb_val;
    logic [PC_W-1:0] pc_lvl;
    logic [7:0] pa_lvl_byte, pa_lat_byte;
    logic [7:0] pb_lvl_byte, pc_lvl_byte;
    logic irq_a_d, irq_b_d, tevt_d;

    // Gathers the four port A pins from their byte positions
    function automatic logic [3:0] pa_pick(input logic [7:0] b);
        pa_pick = {b[gpabc_pkg::PA_BIT3], b[gpabc_pkg::PA_BIT2],
                   b[gpabc_pkg::PA_BIT1], b[gpabc_pkg::PA_BIT0]};
    endfunction : pa_pick

    function automatic logic [7:0] pa_spread(input logic [3:0] p);
        logic [7:0] b;
        b = 8'h00;
        b[gpabc_pkg::PA_BIT0] = p[0];
        b[gpabc_pkg::PA_BIT1] = p[1];
        b[gpabc_pkg::PA_BIT2] = p[2];
        b[gpabc_pkg::PA_BIT3] = p[3];
        pa_spread = b;
    endfunction : pa_spread

    // Byte write strobe for one address
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target,
                                    input logic wr);
        wr_hit = wr & (a == target);
    endfunction : wr_hit

    wire wr_pa_data = wr_hit(sfr_addr, gpabc_pkg::ADDR_PA_DATA, sfr_wr);
    wire wr_pa_dir = wr_hit(sfr_addr, gpabc_pkg::ADDR_PA_DIR, sfr_wr);
    wire wr_pa_pu = wr_hit(sfr_addr, gpabc_pkg::ADDR_PA_PU, sfr_wr);
    wire wr_pa_od = wr_hit(sfr_addr, gpabc_pkg::ADDR_PA_OD, sfr_wr);
    wire wr_pa_fsel = wr_hit(sfr_addr, gpabc_pkg::ADDR_PA_FSEL, sfr_wr);
    wire wr_pb_data = wr_hit(sfr_addr, gpabc_pkg::ADDR_PB_DATA, sfr_wr);
    wire wr_pb_dir = wr_hit(sfr_addr, gpabc_pkg::ADDR_PB_DIR, sfr_wr);
    wire wr_pb_pu = wr_hit(sfr_addr, gpabc_pkg::ADDR_PB_PU, sfr_wr);
    wire wr_pb_od = wr_hit(sfr_addr, gpabc_pkg::ADDR_PB_OD, sfr_wr);
    wire wr_pb_fsel = wr_hit(sfr_addr, gpabc_pkg::ADDR_PB_FSEL, sfr_wr);
    wire wr_pc_data = wr_hit(sfr_addr, gpabc_pkg::ADDR_PC_DATA, sfr_wr);
    wire wr_pc_dir = wr_hit(sfr_addr, gpabc_pkg::ADDR_PC_DIR, sfr_wr);
    wire wr_pc_pu = wr_hit(sfr_addr, gpabc_pkg::ADDR_PC_PU, sfr_wr);
    wire wr_pc_od = wr_hit(sfr_addr, gpabc_pkg::ADDR_PC_OD, sfr_wr);

    // Whole-byte writes only; unimplemented bits are masked away
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pa_data_q <= gpabc_pkg::RST_BYTE;
            pa_dir_q <= gpabc_pkg::RST_BYTE;
            pa_pu_q <= gpabc_pkg::RST_BYTE;
            pa_od_q <= gpabc_pkg::RST_BYTE;
            pa_fsel_q <= gpabc_pkg::RST_BYTE;
        end else if (clk_en) begin
            if (wr_pa_data) pa_data_q <= sfr_wdata & gpabc_pkg::PA_DATA_MASK;
            if (wr_pa_dir) pa_dir_q <= sfr_wdata & gpabc_pkg::PA_DATA_MASK;
            if (wr_pa_pu) pa_pu_q <= sfr_wdata & gpabc_pkg::PA_DATA_MASK;
            if (wr_pa_od) pa_od_q <= sfr_wdata & gpabc_pkg::PA_DATA_MASK;
            if (wr_pa_fsel) pa_fsel_q <= sfr_wdata & gpabc_pkg::PA_FSEL_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pb_data_q <= gpabc_pkg::RST_BYTE;
            pb_dir_q <= gpabc_pkg::RST_BYTE;
            pb_pu_q <= gpabc_pkg::RST_BYTE;
            pb_od_q <= gpabc_pkg::RST_BYTE;
            pb_fsel_q <= gpabc_pkg::RST_BYTE;
        end else if (clk_en) begin
            if (wr_pb_data) pb_data_q <= sfr_wdata & gpabc_pkg::PB_MASK;
            if (wr_pb_dir) pb_dir_q <= sfr_wdata & gpabc_pkg::PB_MASK;
            if (wr_pb_pu) pb_pu_q <= sfr_wdata & gpabc_pkg::PB_MASK;
            if (wr_pb_od) pb_od_q <= sfr_wdata & gpabc_pkg::PB_MASK;
            if (wr_pb_fsel) pb_fsel_q <= sfr_wdata & gpabc_pkg::PB_MASK;
        end
    end

    // Port C reset value is not given; zero keeps pins as floating inputs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc_data_q <= gpabc_pkg::RST_BYTE;
            pc_dir_q <= gpabc_pkg::RST_BYTE;
            pc_pu_q <= gpabc_pkg::RST_BYTE;
            pc_od_q <= gpabc_pkg::RST_BYTE;
        end else if (clk_en) begin
            if (wr_pc_data) pc_data_q <= sfr_wdata & gpabc_pkg::PC_MASK;
            if (wr_pc_dir) pc_dir_q <= sfr_wdata & gpabc_pkg::PC_MASK;
            if (wr_pc_pu) pc_pu_q <= sfr_wdata & gpabc_pkg::PC_MASK;
            if (wr_pc_od) pc_od_q <= sfr_wdata & gpabc_pkg::PC_MASK;
        end
    end

    // Function selects per port A pin: 7 irq B, 6 irq A, 4 buzzer, 1 timer event
    assign pa_fs = pa_pick(pa_fsel_q);
    // Only the buzzer pin is a peripheral output; the others are peripheral inputs
    assign pa_alt_is_out = {1'b0, 1'b0, pa_fs[1], 1'b0};
    assign pa_alt_is_in = pa_fs & ~pa_alt_is_out;
    assign pa_alt_out = {1'b0, 1'b0, buzzer_out, 1'b0};
    // Peripheral overrides the latch and forces the pin direction
    assign pa_val = (pa_pick(pa_data_q) & ~pa_fs) | (pa_alt_out & pa_fs);
    assign pa_dir = (pa_pick(pa_dir_q) & ~pa_alt_is_in) | pa_alt_is_out;
    assign pa_od = pa_pick(pa_od_q);
    assign pa_pu = pa_pick(pa_pu_q);

    assign pb_val = pb_fsel_q[gpabc_pkg::FS_PWM] ? timer2_wave_out
                                                  : pb_data_q[0];
    assign pb_dir = pb_dir_q[0] | pb_fsel_q[gpabc_pkg::FS_PWM];

    genvar gi;
    generate
        for (gi = 0; gi < PA_W; gi++) begin : g_pa
            gpabc_pin u_pin (
                .core_clk(core_clk), .srst(srst), .clk_en(clk_en),
                .dir_out(pa_dir[gi]), .open_drain(pa_od[gi]), .pullup_sel(pa_pu[gi]),
                .out_val(pa_val[gi]), .pad_in(pa_pad_in[gi]),
                .pad_out(pa_pad_out[gi]), .pad_oe(pa_pad_oe[gi]),
                .pad_pu(pa_pad_pu[gi]), .pin_level(pa_lvl[gi])
            );
        end
        for (gi = 0; gi < PB_W; gi++) begin : g_pb
            gpabc_pin u_pin (
                .core_clk(core_clk), .srst(srst), .clk_en(clk_en),
                .dir_out(pb_dir[gi]), .open_drain(pb_od_q[gi]), .pullup_sel(pb_pu_q[gi]),
                .out_val(pb_val[gi]), .pad_in(pb_pad_in[gi]),
                .pad_out(pb_pad_out[gi]), .pad_oe(pb_pad_oe[gi]),
                .pad_pu(pb_pad_pu[gi]), .pin_level(pb_lvl[gi])
            );
        end
        for (gi = 0; gi < PC_W; gi++) begin : g_pc
            gpabc_pin u_pin (
                .core_clk(core_clk), .srst(srst), .clk_en(clk_en),
                .dir_out(pc_dir_q[gi]), .open_drain(pc_od_q[gi]), .pullup_sel(pc_pu_q[gi]),
                .out_val(pc_data_q[gi]), .pad_in(pc_pad_in[gi]),
                .pad_out(pc_pad_out[gi]), .pad_oe(pc_pad_oe[gi]),
                .pad_pu(pc_pad_pu[gi]), .pin_level(pc_lvl[gi])
            );
        end
    endgenerate

    // Peripheral inputs see the synchronised pin, low while not selected
    assign irq_a_d = pa_fsel_q[gpabc_pkg::FS_EXT_IRQ_A] & pa_lvl[2];
    assign irq_b_d = pa_fsel_q[gpabc_pkg::FS_EXT_IRQ_B] & pa_lvl[3];
    assign tevt_d = pa_fsel_q[gpabc_pkg::FS_TIMER_EVT] & pa_lvl[0];
    // UART has no port A pin here; RX select is passed on as enable, TX select is gated by uart_tx_out
    wire uart_tx_en_d = pa_fsel_q[gpabc_pkg::FS_UART_TX] & uart_tx_out;
    wire uart_rx_en_d = pa_fsel_q[gpabc_pkg::FS_UART_RX];

    assign pa_lvl_byte = pa_spread(pa_lvl);
    assign pa_lat_byte = pa_data_q;
    assign pb_lvl_byte = {7'h00, pb_lvl};
    assign pc_lvl_byte = {2'h0, pc_lvl};

    // Write-only registers read as zero; only data registers answer
    always_comb begin
        rdata_d = 8'h00;
        if (sfr_addr == gpabc_pkg::ADDR_PA_DATA)
            rdata_d = sfr_rd_pin ? pa_lvl_byte : pa_lat_byte;
        else if (sfr_addr == gpabc_pkg::ADDR_PB_DATA)
            rdata_d = sfr_rd_pin ? pb_lvl_byte : pb_data_q;
        else if (sfr_addr == gpabc_pkg::ADDR_PC_DATA)
            rdata_d = sfr_rd_pin ? pc_lvl_byte : pc_data_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
            sfr_rvalid <= 1'b0;
            ext_irq_a_in <= 1'b0;
            ext_irq_b_in <= 1'b0;
            timer_event_in <= 1'b0;
            uart_tx_en <= 1'b0;
            uart_rx_en <= 1'b0;
        end else if (clk_en) begin
            sfr_rdata <= sfr_rd ? rdata_d : 8'h00;
            sfr_rvalid <= sfr_rd;
            ext_irq_a_in <= irq_a_d;
            ext_irq_b_in <= irq_b_d;
            timer_event_in <= tevt_d;
            uart_tx_en <= uart_tx_en_d;
            uart_rx_en <= uart_rx_en_d;
        end
    end
endmodule : gpabc_ports

// [bench/gpabc_pad_model.sv]
// Purpose: Board side of a group of port pins.
// Assumes: Device output wins over the external driver.
// Notes: An undriven pin without pull-up toggles every cycle.
`timescale 1ns/1ns
module gpabc_pad_model #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pu,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pad_in
);
    logic [W-1:0] float_q = '0;
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    // Floating pin must not look like a stable level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pu | float_q));
endmodule : gpabc_pad_model

// [bench/gpabc_ports_sva.sv]
// Purpose: Bus and pad checks for gpabc_ports.
// Assumes: One clock, synchronous reset.
// Notes: Bound to every gpabc_ports instance.
`timescale 1ns/1ns
module gpabc_ports_sva #(
    parameter int PA_W = 4,
    parameter int PB_W = 1,
    parameter int PC_W = 6
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rd_pin,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic [PA_W-1:0] pa_pad_oe,
    input wire logic [PA_W-1:0] pa_pad_pu,
    input wire logic [PB_W-1:0] pb_pad_in,
    input wire logic [PB_W-1:0] pb_pad_oe,
    input wire logic [PC_W-1:0] pc_pad_oe,
    input wire logic ext_irq_a_in
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    rst_clear_a: assert property ($fell(srst) && $past(clk_en) |-> pa_pad_oe == '0
        && pa_pad_pu == '0 && pb_pad_oe == '0 && pc_pad_oe == '0 && !ext_irq_a_in && !sfr_rvalid)
        else $error("state not cleared by reset");
    rd_answer_a: assert property (clk_en && sfr_rd |=> sfr_rvalid)
        else $error("read not answered");
    rd_idle_a: assert property (clk_en && !sfr_rd |=> !sfr_rvalid && sfr_rdata == 8'h00)
        else $error("read data without read");
    wo_zero_a: assert property (clk_en && sfr_rd && sfr_addr inside {8'ha0, 8'ha1,
        8'ha2, 8'ha5, 8'ha6, 8'ha7, 8'haa, 8'hab, 8'hc1, 8'hc3, 8'hc5} |=> sfr_rdata == 8'h00)
        else $error("write-only register readable");
    pa_mask_a: assert property (clk_en && sfr_rd && sfr_addr == 8'hc0
        |=> (sfr_rdata & 8'h2d) == 8'h00) else $error("port A spare bit set");
    pb_mask_a: assert property (clk_en && sfr_rd && sfr_addr == 8'hc2
        |=> (sfr_rdata & 8'hfe) == 8'h00) else $error("port B spare bit set");
    pc_mask_a: assert property (clk_en && sfr_rd && sfr_addr == 8'hc4
        |=> (sfr_rdata & 8'hc0) == 8'h00) else $error("port C spare bit set");
    pin_read_a: assert property ((clk_en && $stable(pb_pad_in))[*3] ##0
        (sfr_rd && sfr_rd_pin && sfr_addr == 8'hc2) |=> sfr_rdata[0] == $past(pb_pad_in[0]))
        else $error("pin read wrong");
    latch_read_a: assert property (clk_en && sfr_wr && sfr_addr == 8'hc2 ##1 !sfr_wr
        ##1 (clk_en && sfr_rd && !sfr_rd_pin && sfr_addr == 8'hc2)
        |=> sfr_rdata[0] == $past(sfr_wdata[0], 3)) else $error("latch read wrong");
endmodule : gpabc_ports_sva
bind gpabc_ports gpabc_ports_sva #(.PA_W(PA_W), .PB_W(PB_W), .PC_W(PC_W)) u_sva (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rd_pin(sfr_rd_pin),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .pa_pad_oe(pa_pad_oe),
    .pa_pad_pu(pa_pad_pu), .pb_pad_in(pb_pad_in), .pb_pad_oe(pb_pad_oe),
    .pc_pad_oe(pc_pad_oe), .ext_irq_a_in(ext_irq_a_in));

// [bench/tb.sv]
// Purpose: Self-checking bench for gpabc_ports.
// Assumes: Pad models stand in for the board.
// Notes: Random data from a fixed seed.
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rd_pin = 1'b0, sfr_rvalid;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, dir, p, q;
    logic buz = 1'b0, utx = 1'b0, t2 = 1'b0, irq_a, irq_b, tev, utx_en, urx_en;
    logic [3:0] pa_i, pa_o, pa_e, pa_p, pa_xe = 4'h0, pa_xv = 4'h0;
    logic [0:0] pb_i, pb_o, pb_e, pb_p, pb_xe = 1'b0, pb_xv = 1'b0;
    logic [5:0] pc_i, pc_o, pc_e, pc_p, pc_xe = 6'h00, pc_xv = 6'h00;
    logic [7:0] wo[12] = '{8'ha0, 8'ha1, 8'ha2, 8'ha5, 8'ha6, 8'ha7, 8'haa, 8'hab,
        8'hc1, 8'hc3, 8'hc5, 8'h99};
    int fb[3] = '{6, 7, 1};
    logic [2:0] fx[3] = '{3'b010, 3'b100, 3'b001};
    int miscompares = 0, cmp_count = 0;
    always #50 core_clk = ~core_clk;
    gpabc_ports uut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rd_pin(sfr_rd_pin),
        .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .pa_pad_in(pa_i), .pa_pad_out(pa_o),
        .pa_pad_oe(pa_e), .pa_pad_pu(pa_p), .pb_pad_in(pb_i), .pb_pad_out(pb_o),
        .pb_pad_oe(pb_e), .pb_pad_pu(pb_p), .pc_pad_in(pc_i), .pc_pad_out(pc_o),
        .pc_pad_oe(pc_e), .pc_pad_pu(pc_p), .buzzer_out(buz), .uart_tx_out(utx),
        .timer2_wave_out(t2), .ext_irq_a_in(irq_a), .ext_irq_b_in(irq_b),
        .timer_event_in(tev), .uart_tx_en(utx_en), .uart_rx_en(urx_en));
    gpabc_pad_model #(.W(4)) ma (.core_clk(core_clk), .pad_out(pa_o), .pad_oe(pa_e),
        .pad_pu(pa_p), .ext_en(pa_xe), .ext_val(pa_xv), .pad_in(pa_i));
    gpabc_pad_model #(.W(1)) mb (.core_clk(core_clk), .pad_out(pb_o), .pad_oe(pb_e),
        .pad_pu(pb_p), .ext_en(pb_xe), .ext_val(pb_xv), .pad_in(pb_i));
    gpabc_pad_model #(.W(6)) mc (.core_clk(core_clk), .pad_out(pc_o), .pad_oe(pc_e),
        .pad_pu(pc_p), .ext_en(pc_xe), .ext_val(pc_xv), .pad_in(pc_i));
    // Port A pins sit at byte bits 7, 6, 4, 1
    function automatic logic [3:0] pa_map(input logic [7:0] b);
        return {b[7], b[6], b[4], b[1]};
    endfunction : pa_map
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic pin, output logic [7:0] v);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd_pin <= pin;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        chk("rvalid", 16'h0001, {15'h0, sfr_rvalid});
        v = sfr_rdata;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
    initial begin
        d = 8'($urandom(32'hf897));
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        chk("rst_oe", 16'h0000, {pa_e, pb_e, pc_e, pa_p});
        rd(8'hc0, 1'b0, q);
        chk("rst_data", 16'h0000, q);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            dir = (i == 1) ? 8'h2d : 8'($urandom);
            for (int k = 0; k < 3; k++) begin
                wr(8'(8'hc0 + 2 * k), d);
                wr(8'(8'hc1 + 2 * k), dir);
            end
            settle();
            chk("pa_oe", pa_map(dir), pa_e);
            chk("pa_out", pa_map(dir & d), pa_e & pa_o);
            chk("pbc_oe", {dir[0], dir[5:0]}, {pb_e, pc_e});
            chk("pc_out", dir[5:0] & d[5:0], pc_e & pc_o);
            rd(8'hc0, 1'b0, q);
            chk("pa_latch", d & 8'hd2, q);
        end
        for (int k = 0; k < 3; k++) begin
            wr(8'(8'ha0 + k), 8'hff);
        end
        settle();
        chk("od_oe", {pa_map(dir & ~d), dir[0] & ~d[0], dir[5:0] & ~d[5:0]},
            {pa_e, pb_e, pc_e});
        chk("od_out", 16'h0000, {pa_e & pa_o, pb_e & pb_o, pc_e & pc_o});
        for (int k = 0; k < 3; k++) begin
            wr(8'(8'ha0 + k), 8'h00);
        end
        $display("test drive done");
        p = 8'($urandom);
        wr(8'hc1, 8'h00);
        wr(8'hc3, 8'h00);
        wr(8'hc5, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(8'(8'ha5 + k), p);
        end
        settle();
        chk("pullup", {pa_map(p), p[0], p[5:0]}, {pa_p, pb_p, pc_p});
        rd(8'hc4, 1'b1, q);
        chk("pc_pull", p[5:0], q[5:0] & p[5:0]);
        pc_xe <= 6'h3f;
        pc_xv <= d[5:0] ^ 6'h2a;
        pb_xe <= 1'b1;
        pb_xv <= 1'b1;
        settle();
        rd(8'hc4, 1'b1, q);
        chk("pc_pin", d[5:0] ^ 6'h2a, q);
        rd(8'hc2, 1'b1, q);
        chk("pb_pin", 16'h0001, q);
        wr(8'hc2, ~d);
        rd(8'hc2, 1'b0, q);
        chk("pb_latch", {7'h00, ~d[0]}, q);
        $display("test pins done");
        wr(8'h99, 8'hff);
        for (int k = 0; k < 12; k++) begin
            rd(wo[k], 1'b0, q);
            chk("wo_read", 16'h0000, q);
        end
        $display("test write-only done");
        p = {4'h0, d[3:0] ^ 4'h5};
        pa_xe <= 4'hf;
        pa_xv <= p[3:0];
        settle();
        rd(8'hc0, 1'b1, q);
        chk("pa_pin", {p[3], p[2], 1'b0, p[1], 2'b00, p[0], 1'b0}, q);
        pa_xv <= 4'hf;
        for (int k = 0; k < 3; k++) begin
            wr(8'hc1, 8'hd2);
            wr(8'haa, 8'h01 << fb[k]);
            repeat (2) settle();
            chk("fs_oe", pa_map(8'hd2 & ~(8'h01 << fb[k])), pa_e);
            chk("fs_in", fx[k], {irq_b, irq_a, tev});
        end
        pa_xe <= 4'h0;
        wr(8'hc1, 8'h00);
        wr(8'haa, 8'h1c);
        buz <= 1'b1;
        utx <= 1'b1;
        settle();
        chk("buz_uart", 16'h000f, {pa_e[1], pa_o[1], urx_en, utx_en});
        wr(8'hab, 8'h01);
        t2 <= 1'b1;
        settle();
        chk("pwm", 16'h0003, {pb_e, pb_o});
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(8'hab, 8'h00);
        clk_en <= 1'b1;
        settle();
        chk("pwm_hold", 16'h0003, {pb_e, pb_o});
        $display("test select done");
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        chk("rerst", 16'h0000, {pa_e, pb_e, pc_e, pb_p, irq_a, irq_b, tev, urx_en});
        $display("test reset again done");
        test_done();
    end
endmodule : tb
